//--- rtl/bpr_pkg.sv
// Shared constants and types for the buck power-good interrupt router
package bpr_pkg;

   // Sizes
   localparam int BPR_NUM_REG = 3;
   localparam int BPR_NUM_PIN = 7;

   // Register indices; byte address is four times the index
   localparam logic [7:0] BPR_IDX_PIN_STS  = 8'h6F;
   localparam logic [7:0] BPR_IDX_REG1_CFG = 8'h70;
   localparam logic [7:0] BPR_IDX_REG2_CFG = 8'h71;
   localparam logic [7:0] BPR_IDX_REG3_CFG = 8'h72;
   localparam logic [7:0] BPR_IDX_IRQ_STS  = 8'h74;
   localparam logic [7:0] BPR_IDX_IRQ_MASK = 8'h75;
   localparam logic [7:0] BPR_IDX_NONE     = 8'hFF;

   // Field positions
   localparam int BPR_FLAG_BIT      = 7;
   localparam int BPR_ROUTE_LSB     = 0;
   localparam int BPR_IDX_ADDR_LSB  = 2;
   localparam int BPR_IDX_ADDR_MSB  = 9;

   // Values after reset
   localparam logic [6:0] BPR_ROUTE_RST = 7'h00;
   localparam logic [2:0] BPR_MASK_RST  = 3'h0;
   localparam logic [2:0] BPR_FLAG_RST  = 3'h0;

   // AXI response codes
   localparam logic [1:0] BPR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] BPR_RESP_SLVERR = 2'h2;

   // Regulator selector
   typedef enum logic [1:0]
   {
      BPR_SEL_REG1,
      BPR_SEL_REG2,
      BPR_SEL_REG3,
      BPR_SEL_NONE
   } bpr_sel_t;

endpackage

//--- rtl/bpr_pg_edge.sv
// Power-good change detector, one pulse per level change
`timescale 1ns/1ns
`default_nettype none

module bpr_pg_edge
#(
   parameter int N = 3
)
(
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [N-1:0] level,
   output var  logic [N-1:0] change
);

   typedef struct packed
   {
      logic         primed;
      logic [N-1:0] prev;
      logic [N-1:0] change;
   } bpr_edge_state_t;

   bpr_edge_state_t s_q;
   bpr_edge_state_t s_d;

   always_comb
   begin
      s_d        = s_q;
      s_d.primed = 1'b1;
      s_d.prev   = level;
      // First sample after reset only primes the history
      s_d.change = s_q.primed ? (level ^ s_q.prev) : '0;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign change = s_q.change;

endmodule

`default_nettype wire

//--- rtl/bpr_router.sv
// Buck power-good interrupt router with AXI4-Lite register access
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Bit 7 of a regulator's config byte reads 1 after a power-good change; writes ignore it.
// - Bit 7 reads 0 while no power-good change of that regulator is pending.
// - Second regulator: route bit n of 6..0 set sends its interrupt to pin n.
// - A clear route bit keeps that regulator's interrupt off that pin.
// - First regulator: route bits 6..0 set send its interrupt to the pin of equal index.
// - First regulator bit 1 set routes its interrupt to pin 1.
// - A read-only pin status byte shows each regulator's active interrupt, third in bit 2.
module bpr_router
#(
   parameter int ADDR_W = 12
)
(
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   input  wire logic [ADDR_W-1:0]             awaddr,
   input  wire logic                          awvalid,
   output var  logic                          awready,
   input  wire logic [31:0]                   wdata,
   input  wire logic [3:0]                    wstrb,
   input  wire logic                          wvalid,
   output var  logic                          wready,
   output var  logic [1:0]                    bresp,
   output var  logic                          bvalid,
   input  wire logic                          bready,
   input  wire logic [ADDR_W-1:0]             araddr,
   input  wire logic                          arvalid,
   output var  logic                          arready,
   output var  logic [31:0]                   rdata,
   output var  logic [1:0]                    rresp,
   output var  logic                          rvalid,
   input  wire logic                          rready,
   input  wire logic [bpr_pkg::BPR_NUM_REG-1:0] power_good,
   output var  logic [bpr_pkg::BPR_NUM_PIN-1:0] multipurpose_pin_irq,
   output var  logic                          irq
);

   import bpr_pkg::*;

   typedef struct packed
   {
      logic [BPR_NUM_REG-1:0][BPR_NUM_PIN-1:0] route;
      logic [BPR_NUM_REG-1:0]                  flag;
      logic [BPR_NUM_REG-1:0]                  irq_sts;
      logic [BPR_NUM_REG-1:0]                  irq_mask;
      logic [BPR_NUM_PIN-1:0]                  pin;
      logic                                    irq;
      logic                                    aw_got;
      logic                                    w_got;
      logic [ADDR_W-1:0]                       waddr;
      logic [7:0]                              wbyte;
      logic                                    wen;
      logic                                    awready;
      logic                                    wready;
      logic                                    bvalid;
      logic [1:0]                              bresp;
      logic                                    arready;
      logic                                    rvalid;
      logic [1:0]                              rresp;
      logic [7:0]                              rbyte;
   } bpr_state_t;

   bpr_state_t             s_q;
   bpr_state_t             s_d;
   logic [BPR_NUM_REG-1:0] pg_change;

   // Byte address to register index, out-of-range maps to none
   function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] hi;
      hi = a >> (BPR_IDX_ADDR_MSB + 1);
      if (hi != '0)
      begin
         word_index = BPR_IDX_NONE;
      end
      else
      begin
         word_index = a[BPR_IDX_ADDR_MSB:BPR_IDX_ADDR_LSB];
      end
   endfunction

   // Which regulator a config index belongs to
   function automatic bpr_sel_t cfg_sel(input logic [7:0] idx);
      case (idx)
         BPR_IDX_REG1_CFG: cfg_sel = BPR_SEL_REG1;
         BPR_IDX_REG2_CFG: cfg_sel = BPR_SEL_REG2;
         BPR_IDX_REG3_CFG: cfg_sel = BPR_SEL_REG3;
         default:          cfg_sel = BPR_SEL_NONE;
      endcase
   endfunction

   function automatic logic is_mapped(input logic [7:0] idx);
      is_mapped = (cfg_sel(idx) != BPR_SEL_NONE)
                  || (idx == BPR_IDX_PIN_STS)
                  || (idx == BPR_IDX_IRQ_STS)
                  || (idx == BPR_IDX_IRQ_MASK);
   endfunction

   // Read value of a register, bits above the field read zero
   function automatic logic [7:0] read_byte(input logic [7:0] idx, input bpr_state_t st);
      bpr_sel_t sel;
      sel       = cfg_sel(idx);
      read_byte = 8'h00;
      if (sel != BPR_SEL_NONE)
      begin
         read_byte[BPR_FLAG_BIT] = st.flag[sel];
         read_byte[BPR_ROUTE_LSB +: BPR_NUM_PIN] = st.route[sel];
      end
      else if (idx == BPR_IDX_PIN_STS)
      begin
         read_byte[BPR_NUM_REG-1:0] = st.flag;
      end
      else if (idx == BPR_IDX_IRQ_STS)
      begin
         read_byte[BPR_NUM_REG-1:0] = st.irq_sts;
      end
      else if (idx == BPR_IDX_IRQ_MASK)
      begin
         read_byte[BPR_NUM_REG-1:0] = st.irq_mask;
      end
   endfunction

   bpr_pg_edge
   #(
      .N (BPR_NUM_REG)
   )
   u_pg_edge
   (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .level  (power_good),
      .change (pg_change)
   );

   always_comb
   begin
      logic [7:0]             wr_idx;
      logic [7:0]             rd_idx;
      logic                   wr_fire;
      logic                   rd_fire;
      logic [BPR_NUM_REG-1:0] clr_flag;
      logic                   clr_sts;
      bpr_sel_t               wsel;
      bpr_sel_t               rsel;

      s_d      = s_q;
      clr_flag = '0;
      clr_sts  = 1'b0;
      wr_idx   = word_index(s_q.waddr);
      rd_idx   = word_index(araddr);
      wsel     = cfg_sel(wr_idx);
      rsel     = cfg_sel(rd_idx);
      wr_fire  = s_q.aw_got && s_q.w_got && !s_q.bvalid;
      rd_fire  = arvalid && s_q.arready;

      // Write address and data taken in either order
      if (awvalid && s_q.awready)
      begin
         s_d.aw_got = 1'b1;
         s_d.waddr  = awaddr;
      end
      if (wvalid && s_q.wready)
      begin
         s_d.w_got = 1'b1;
         s_d.wbyte = wdata[7:0];
         s_d.wen   = wstrb[0];
      end

      // Write commit
      if (wr_fire)
      begin
         s_d.bvalid = 1'b1;
         s_d.bresp  = is_mapped(wr_idx) ? BPR_RESP_OKAY : BPR_RESP_SLVERR;
         if (s_q.wen)
         begin
            if (wsel != BPR_SEL_NONE)
            begin
               // Status bit is read-only, only route bits store
               s_d.route[wsel] = s_q.wbyte[BPR_ROUTE_LSB +: BPR_NUM_PIN];
            end
            else if (wr_idx == BPR_IDX_IRQ_MASK)
            begin
               s_d.irq_mask = s_q.wbyte[BPR_NUM_REG-1:0];
            end
         end
      end
      if (s_q.bvalid && bready)
      begin
         s_d.bvalid = 1'b0;
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
      end

      // Read, with clear-on-read side effects
      if (rd_fire)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = is_mapped(rd_idx) ? BPR_RESP_OKAY : BPR_RESP_SLVERR;
         s_d.rbyte  = read_byte(rd_idx, s_q);
         if (rsel != BPR_SEL_NONE)
         begin
            clr_flag[rsel] = 1'b1;
         end
         if (rd_idx == BPR_IDX_IRQ_STS)
         begin
            clr_sts = 1'b1;
         end
      end
      if (s_q.rvalid && rready)
      begin
         s_d.rvalid = 1'b0;
      end

      // Change flags, a new change beats a clear
      s_d.flag    = (s_q.flag & ~clr_flag) | pg_change;
      s_d.irq_sts = (clr_sts ? '0 : s_q.irq_sts) | pg_change;

      // Pin drive from pending flags and route bits
      for (int p = 0; p < BPR_NUM_PIN; p++)
      begin
         s_d.pin[p] = 1'b0;
         for (int r = 0; r < BPR_NUM_REG; r++)
         begin
            s_d.pin[p] = s_d.pin[p] | (s_d.flag[r] & s_d.route[r][p]);
         end
      end

      s_d.irq = |(s_d.irq_sts & s_d.irq_mask);

      // Ready while idle on each channel
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready  = !s_d.w_got && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q          <= '0;
         s_q.route    <= {BPR_NUM_REG{BPR_ROUTE_RST}};
         s_q.flag     <= BPR_FLAG_RST;
         s_q.irq_mask <= BPR_MASK_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign awready              = s_q.awready;
   assign wready               = s_q.wready;
   assign bvalid               = s_q.bvalid;
   assign bresp                = s_q.bresp;
   assign arready              = s_q.arready;
   assign rvalid               = s_q.rvalid;
   assign rresp                = s_q.rresp;
   assign rdata                = {24'h000000, s_q.rbyte};
   assign multipurpose_pin_irq = s_q.pin;
   assign irq                  = s_q.irq;

endmodule

`default_nettype wire

//--- test/bpr_router_checker.sv
// Assertion checker for the power-good interrupt router
`timescale 1ns/1ns
`default_nettype none
module bpr_router_checker
(
   input  wire logic                              mclk,
   input  wire logic                              rst_n,
   input  wire logic                              arvalid,
   input  wire logic                              arready,
   input  wire logic                              rvalid,
   input  wire logic                              rready,
   input  wire logic [31:0]                       rdata,
   input  wire logic                              bvalid,
   input  wire logic                              bready,
   input  wire logic [1:0]                        bresp,
   input  wire logic [bpr_pkg::BPR_NUM_REG-1:0]   power_good,
   input  wire logic [bpr_pkg::BPR_NUM_PIN-1:0]   multipurpose_pin_irq,
   input  wire logic                              irq
);
   import bpr_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_rd_take; arvalid && arready; endsequence
   sequence s_pg_chg; $past(power_good, 2) != $past(power_good, 3); endsequence
   sequence s_clear; rvalid || $past(rvalid) || $rose(bvalid); endsequence
   property p_rd_lat; s_rd_take |=> rvalid; endproperty
   property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   property p_rd_upper; rvalid |-> rdata[31:8] == 24'h0; endproperty
   property p_pin_rise;
      (|(multipurpose_pin_irq & ~$past(multipurpose_pin_irq))) |-> s_pg_chg or $rose(bvalid);
   endproperty
   property p_pin_fall;
      (|($past(multipurpose_pin_irq) & ~multipurpose_pin_irq)) |-> s_clear;
   endproperty
   property p_irq_rise; $rose(irq) |-> s_pg_chg or $rose(bvalid); endproperty
   property p_irq_fall; $fell(irq) |-> s_clear; endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data not held");
   a_b_hold: assert property (p_b_hold)
      else $error("write response not held");
   a_rd_upper: assert property (p_rd_upper)
      else $error("upper read bits not zero");
   a_pin_rise: assert property (p_pin_rise)
      else $error("pin raised without cause");
   a_pin_fall: assert property (p_pin_fall)
      else $error("pin dropped without clear");
   a_irq_rise: assert property (p_irq_rise)
      else $error("irq raised without cause");
   a_irq_fall: assert property (p_irq_fall)
      else $error("irq dropped without clear");
endmodule
bind bpr_router bpr_router_checker chk_u (.mclk, .rst_n, .arvalid, .arready, .rvalid, .rready,
   .rdata, .bvalid, .bready, .bresp, .power_good, .multipurpose_pin_irq, .irq);
`default_nettype wire

//--- test/bpr_host_model.sv
// Host model counting interrupt arrivals on the pins
`timescale 1ns/1ns
`default_nettype none
module bpr_host_model
(
   input  wire logic [6:0] pin,
   input  wire logic       mclk,
   input  wire logic       rst_n,
   output var  logic [7:0] rise_cnt
);
   logic [6:0] seen_q;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seen_q   <= 7'h00;
         rise_cnt <= 8'h00;
      end
      else
      begin
         seen_q <= pin;
         if (|(pin & ~seen_q))
            rise_cnt <= rise_cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

//--- test/bpr_router_test.sv
// Self-checking bench for the power-good interrupt router
`timescale 1ns/1ns
`default_nettype none
module bpr_router_test;
   import bpr_pkg::*;
   logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic [2:0]  power_good;
   wire  logic  awready, wready, bvalid, arready, rvalid, irq;
   wire  logic [1:0]  bresp, rresp;
   wire  logic [31:0] rdata;
   wire  logic [6:0]  multipurpose_pin_irq;
   wire  logic [7:0]  rise_cnt;
   int          bad_count, checked, cyc;
   int          stall;

   bpr_router #(.ADDR_W(12)) dut_u (.mclk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .power_good, .multipurpose_pin_irq, .irq);
   bpr_host_model host_u (.mclk, .rst_n, .pin(multipurpose_pin_irq), .rise_cnt);

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [11:0] adr(logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction
   task automatic wr(logic [7:0] idx, logic [7:0] d, logic [1:0] er);
      bit a, w;
      a = 0;
      w = 0;
      awaddr  <= adr(idx);
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= (stall == 0);
      while (!(a && w))
      begin
         @(posedge mclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         a = a | awready;
         w = w | wready;
      end
      if (stall != 0)
      begin
         repeat (stall) @(posedge mclk);
         bready <= 1'b1;
      end
      do @(posedge mclk); while (!bvalid);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge mclk);
   endtask
   task automatic rd(logic [7:0] idx, logic [7:0] e, logic [1:0] er);
      araddr  <= adr(idx);
      arvalid <= 1'b1;
      rready  <= (stall == 0);
      do @(posedge mclk); while (!arready);
      arvalid <= 1'b0;
      if (stall != 0)
      begin
         repeat (stall) @(posedge mclk);
         rready <= 1'b1;
      end
      do @(posedge mclk); while (!rvalid);
      rready <= 1'b0;
      chk(rdata, {24'h0, e});
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge mclk);
   endtask
   task automatic pg(logic [2:0] v);
      power_good <= v;
      repeat (3) @(posedge mclk);
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad_count++;
         end_of_test();
      end
   end
   initial
   begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, power_good} = 59'h0;
      wstrb = 4'hF;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(BPR_IDX_REG1_CFG, 8'h00, BPR_RESP_OKAY);
      rd(BPR_IDX_PIN_STS, 8'h00, BPR_RESP_OKAY);
      wr(BPR_IDX_REG1_CFG, 8'h23, BPR_RESP_OKAY);
      wr(BPR_IDX_REG2_CFG, 8'h55, BPR_RESP_OKAY);
      wr(BPR_IDX_REG3_CFG, 8'hA9, BPR_RESP_OKAY);
      stall = 3;
      wr(BPR_IDX_IRQ_MASK, 8'h02, BPR_RESP_OKAY);
      rd(BPR_IDX_REG3_CFG, 8'h29, BPR_RESP_OKAY);
      stall = 0;
      rd(BPR_IDX_IRQ_MASK, 8'h02, BPR_RESP_OKAY);
      pg(3'h2);
      chk({25'h0, multipurpose_pin_irq}, 32'h55);
      chk({31'h0, irq}, 32'h1);
      rd(BPR_IDX_PIN_STS, 8'h02, BPR_RESP_OKAY);
      rd(BPR_IDX_IRQ_STS, 8'h02, BPR_RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      rd(BPR_IDX_REG2_CFG, 8'hD5, BPR_RESP_OKAY);
      chk({25'h0, multipurpose_pin_irq}, 32'h0);
      rd(BPR_IDX_REG2_CFG, 8'h55, BPR_RESP_OKAY);
      pg(3'h7);
      chk({25'h0, multipurpose_pin_irq}, 32'h2B);
      chk({31'h0, irq}, 32'h0);
      rd(BPR_IDX_PIN_STS, 8'h05, BPR_RESP_OKAY);
      rd(BPR_IDX_REG1_CFG, 8'hA3, BPR_RESP_OKAY);
      chk({25'h0, multipurpose_pin_irq}, 32'h29);
      rd(BPR_IDX_REG3_CFG, 8'hA9, BPR_RESP_OKAY);
      chk({25'h0, multipurpose_pin_irq}, 32'h0);
      wr(8'h73, 8'h01, BPR_RESP_SLVERR);
      rd(8'h73, 8'h00, BPR_RESP_SLVERR);
      chk({24'h0, rise_cnt}, 32'h2);
      end_of_test();
   end
endmodule
`default_nettype wire
